// ---- pkg/fcs_pkg.sv ----
// fcs_pkg.sv: constants and carrier types of the flash command sequencer
package fcs_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFS_STATUS   = 8'h00;  // flash_status_register
    localparam logic [7:0] OFS_INDEX    = 8'h02;  // command_index_register
    localparam logic [7:0] OFS_OBJECT   = 8'h0a;  // command_object_array window
    localparam logic [7:0] OFS_SECURITY = 8'h01;  // security state byte
    localparam logic [7:0] OFS_CONTROL  = 8'h03;  // secured status bit, read only

    // status bit positions
    localparam int BIT_DONE  = 7;  // command complete
    localparam int BIT_ACC   = 5;  // access error
    localparam int BIT_PV    = 4;  // protection violation
    localparam int BIT_VERR  = 1;  // verify error
    localparam int BIT_VUNC  = 0;  // verify uncorrectable

    // command codes and launch index values
    localparam logic [7:0] CMD_ERASE_VERIFY_SECT = 8'h03;
    localparam logic [7:0] CMD_READ_ONCE         = 8'h04;
    localparam logic [7:0] CMD_PROGRAM_PHRASE    = 8'h06;
    localparam logic [7:0] CMD_PROGRAM_ONCE      = 8'h07;
    localparam logic [2:0] IDX_LAUNCH_PROG       = 3'h5;  // 101
    localparam logic [2:0] IDX_LAUNCH_EVS        = 3'h2;  // 010
    localparam logic [2:0] IDX_LAUNCH_ONCE       = 3'h1;  // 001
    localparam logic [2:0] PHRASE_ALIGN          = 3'h0;  // 000

    // memory map
    localparam logic [22:0] PFLASH_BASE   = 23'h7c0000;  // valid p-flash start
    localparam logic [22:0] BLOCK0_BASE   = 23'h7c0000;  // block 0 start
    localparam int          SECT_BOUND_LG = 18;          // 256 kbyte boundary
    localparam logic [15:0] ONCE_MAX_IDX  = 16'h0007;    // last once phrase
    localparam logic [1:0]  STATE_UNSECURED = 2'h2;      // only unsecured code

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_NS  = 2000;  // array program pulse
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_PROG   = 5'h02,
        ST_VERIFY = 5'h04,
        ST_EVS    = 5'h08,
        ST_ONCE   = 5'h10
    } fcs_state_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } fcs_req_t;

    // array port request and answer
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        info;
        logic [22:0] addr;
        logic [15:0] wdata;
    } fcs_arr_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic        err;
        logic        unc;
    } fcs_arr_rsp_t;
endpackage : fcs_pkg

// ---- rtl/fcs_word_mem.sv ----
// fcs_word_mem.sv: command object word store with registered read data
`timescale 1ns/1ns
`default_nettype none
module fcs_word_mem #(
    parameter int DEPTH = 8,   // words
    parameter int AW    = 3    // address width
) (
    input  wire logic          sys_clk,  // clock
    input  wire logic          we,       // write enable
    input  wire logic [AW-1:0] waddr,    // write address
    input  wire logic [15:0]   wdata,    // write data
    input  wire logic [AW-1:0] raddr,    // read address
    output logic      [15:0]   rdata     // registered read data
);
    logic [15:0] mem [DEPTH];  // storage

    // write port and registered read port
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : fcs_word_mem
`default_nettype wire

// ---- rtl/fcs_sequencer.sv ----
// fcs_sequencer.sv: flash command launch checks, program/verify and once sequencing
// Functional notes
// - launch programs words then reads back
// - complete flag sets after full program-verify
// - program launch needs index 101
// - command not allowed in mode: access error
// - invalid 23-bit address: access error
// - misaligned phrase address: access error
// - protected program target: protection violation
// - program verify sets error flags
// - program-once writes only reserved 8 phrases
// - erase-verify launch needs index 010
// - erase-verify refused during load data
// - erase-verify crossing 256k: access error
// - erase-verify read sets error flags
// - read-once fetches phrase, then completes
// - block 0 reads invalid during read-once
// - security field 10 unsecured, else secured
// - index register: low bits rw, rest zero
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer #(
    parameter int          PROG_CNT   = fcs_pkg::PROG_CYCLES,  // program pulse cycles
    parameter logic [22:0] PROT_START = 23'h7f8000              // protected area start
) (
    input  wire logic                  sys_clk,      // clock
    input  wire logic                  sys_rst,      // sync reset, high
    input  wire fcs_pkg::fcs_req_t     regReq,       // register port request
    output logic [15:0]                regRdata,     // read data, next cycle
    output fcs_pkg::fcs_arr_req_t      arrReq,       // array request
    input  wire fcs_pkg::fcs_arr_rsp_t arrRsp,       // array answer, same cycle
    input  wire logic                  modeAllowed,  // mode permits commands
    input  wire logic                  loadDataBusy, // load data field active
    output logic                       block0Invalid // block 0 reads invalid
);
    // all state except the word store and the word 0/1 shadows in one struct
    typedef struct packed {
        fcs_pkg::fcs_state_t st;
        logic [2:0]  idx;      // command_word_select
        logic        cmdDone;  // command_complete_flag
        logic        acc;      // access_error_flag
        logic        pv;       // protection_violation_flag
        logic        verr;     // verify_error_flag
        logic        vunc;     // verify_uncorrectable_flag
        logic [1:0]  secState; // security_state_field
        logic [2:0]  word;     // word pointer in program/read
        logic [15:0] cnt;      // pulse counter
        logic        once;     // program-once running
        logic [15:0] rdata;    // read data register
        logic        rdMem;    // read data comes from word store
    } fcs_regs_t;

    fcs_regs_t q;        // registered state
    fcs_regs_t d;        // next state
    logic [15:0] memRd;  // word store read data
    logic        memWe;  // word store write
    logic [2:0]  memWa;  // word store write address
    logic [15:0] memWd;  // word store write data
    logic [2:0]  memRa;  // word store read address
    logic [15:0] w0;     // shadow of word 0
    logic [15:0] w1;     // shadow of word 1
    logic [22:0] gAddr;  // global address of command
    logic        launch; // software clears complete flag

    // decode security: only 10 is unsecured
    function automatic logic isSecured(input logic [1:0] s);
        return s != fcs_pkg::STATE_UNSECURED;
    endfunction : isSecured

    // address in valid p-flash region
    function automatic logic addrValid(input logic [22:0] a);
        return a >= fcs_pkg::PFLASH_BASE;
    endfunction : addrValid
    // byte address of data word k (2..5) within a phrase
    function automatic logic [22:0] wordAddr(input logic [19:0] base, input logic [2:0] k);
        return {base, 2'(k - 3'h2), 1'b0};
    endfunction : wordAddr

    // word store holds the command object array
    fcs_word_mem #(.DEPTH(8), .AW(3)) uMem (
        .sys_clk (sys_clk),
        .we      (memWe),
        .waddr   (memWa),
        .wdata   (memWd),
        .raddr   (memRa),
        .rdata   (memRd)
    );

    // shadow copies of words 0 and 1 for launch checks
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            w0 <= 16'h0000;
            w1 <= 16'h0000;
        end
        else if (memWe && memWa == 3'h0)
        begin
            w0 <= memWd;
        end
        else if (memWe && memWa == 3'h1)
        begin
            w1 <= memWd;
        end
    end

    assign gAddr  = {w0[6:0], w1};
    assign launch = regReq.wr && regReq.addr == fcs_pkg::OFS_STATUS
                    && regReq.wdata[fcs_pkg::BIT_DONE] && q.cmdDone;

    // next-state logic
    always_comb
    begin
        d       = q;
        memWe   = 1'b0;
        memWa   = q.idx;
        memWd   = regReq.wdata;
        memRa   = q.idx;
        arrReq  = '0;
        d.rdMem = 1'b0;
        // register writes
        if (regReq.wr)
        begin
            unique case (regReq.addr)
                fcs_pkg::OFS_INDEX:
                begin
                    d.idx = regReq.wdata[2:0];
                end
                fcs_pkg::OFS_OBJECT:
                begin
                    memWe = q.cmdDone;  // array locked while busy
                end
                fcs_pkg::OFS_SECURITY:
                begin
                    d.secState = regReq.wdata[1:0];
                end
                fcs_pkg::OFS_STATUS:
                begin
                    // write one clears access and protection flags
                    if (regReq.wdata[fcs_pkg::BIT_ACC]) d.acc = 1'b0;
                    if (regReq.wdata[fcs_pkg::BIT_PV])  d.pv  = 1'b0;
                end
                default: ;
            endcase
        end
        // register reads
        if (regReq.rd)
        begin
            unique case (regReq.addr)
                fcs_pkg::OFS_STATUS:
                    d.rdata = {8'h00, q.cmdDone, 1'b0, q.acc, q.pv, 2'b00, q.verr, q.vunc};
                fcs_pkg::OFS_INDEX:    d.rdata = {13'h0000, q.idx};
                fcs_pkg::OFS_SECURITY: d.rdata = {14'h0000, q.secState};
                fcs_pkg::OFS_CONTROL:  d.rdata = {15'h0000, isSecured(q.secState)};
                fcs_pkg::OFS_OBJECT:
                begin
                    d.rdata = 16'h0000;
                    d.rdMem = 1'b1;
                end
                default:               d.rdata = 16'h0000;
            endcase
        end
        // sequencer
        unique case (q.st)
            fcs_pkg::ST_IDLE:
            begin
                if (launch)
                begin
                    d.verr = 1'b0;
                    d.vunc = 1'b0;
                    d.word = 3'h2;
                    d.cnt  = 16'h0000;
                    if (w0[15:8] == fcs_pkg::CMD_PROGRAM_PHRASE)
                    begin
                        if (q.idx != fcs_pkg::IDX_LAUNCH_PROG || !modeAllowed
                            || !addrValid(gAddr)
                            || gAddr[2:0] != fcs_pkg::PHRASE_ALIGN)
                            d.acc = 1'b1;
                        else if (gAddr >= PROT_START)
                            d.pv = 1'b1;
                        else
                        begin
                            d.cmdDone = 1'b0;
                            d.st   = fcs_pkg::ST_PROG;
                        end
                    end
                    else if (w0[15:8] == fcs_pkg::CMD_ERASE_VERIFY_SECT)
                    begin
                        if (q.idx != fcs_pkg::IDX_LAUNCH_EVS || loadDataBusy
                            || !modeAllowed || !addrValid(gAddr)
                            || gAddr[2:0] != fcs_pkg::PHRASE_ALIGN
                            || gAddr[22:fcs_pkg::SECT_BOUND_LG]
                               != 5'(({gAddr[22:3], 3'h0} + 23'h8)
                                     >> fcs_pkg::SECT_BOUND_LG))
                            d.acc = 1'b1;
                        else
                        begin
                            d.cmdDone = 1'b0;
                            d.st      = fcs_pkg::ST_EVS;
                        end
                    end
                    else if (w0[15:8] == fcs_pkg::CMD_READ_ONCE
                             || w0[15:8] == fcs_pkg::CMD_PROGRAM_ONCE)
                    begin
                        if (w1 > fcs_pkg::ONCE_MAX_IDX || !modeAllowed)
                            d.acc = 1'b1;
                        else
                        begin
                            d.once    = w0[15:8] == fcs_pkg::CMD_PROGRAM_ONCE;  // only if started
                            d.cmdDone = 1'b0;
                            d.st      = d.once ? fcs_pkg::ST_PROG : fcs_pkg::ST_ONCE;
                        end
                    end
                    else
                        d.acc = 1'b1;
                end
            end
            fcs_pkg::ST_PROG:
            begin
                // write one data word per pulse
                memRa         = q.word;
                arrReq.wr     = q.cnt == 16'(PROG_CNT - 1);
                arrReq.info   = q.once;
                arrReq.addr   = wordAddr(q.once ? {17'h00000, w1[2:0]} : gAddr[22:3], q.word);
                arrReq.wdata  = memRd;
                d.cnt         = q.cnt + 16'h0001;
                if (arrReq.wr)
                begin
                    d.cnt  = 16'h0000;
                    d.word = q.word + 3'h1;
                    if (q.word == 3'h5)
                    begin
                        d.word = 3'h2;
                        d.st   = fcs_pkg::ST_VERIFY;
                    end
                end
            end
            fcs_pkg::ST_VERIFY, fcs_pkg::ST_EVS:
            begin
                // read back words, flag any fault, and any mismatch in program verify
                memRa       = q.word;
                arrReq.rd   = 1'b1;
                arrReq.info = q.once;
                arrReq.addr = wordAddr(q.once ? {17'h00000, w1[2:0]} : gAddr[22:3], q.word);
                if (arrRsp.err || (q.st == fcs_pkg::ST_VERIFY && q.cnt[0]
                                   && arrRsp.rdata != memRd))
                    d.verr = 1'b1;
                if (arrRsp.unc)
                    d.vunc = 1'b1;
                d.cnt = q.cnt ^ 16'h0001;  // wait a cycle for stored word
                if (q.cnt[0])
                begin
                    d.word = q.word + 3'h1;
                    if (q.word == 3'h5)
                    begin
                        d.cmdDone = 1'b1;
                        d.once = 1'b0;
                        d.st   = fcs_pkg::ST_IDLE;
                    end
                end
            end
            fcs_pkg::ST_ONCE:
            begin
                // fetch reserved phrase into words 2..5
                arrReq.rd   = 1'b1;
                arrReq.info = 1'b1;
                arrReq.addr = wordAddr({17'h00000, w1[2:0]}, q.word);
                memWe       = 1'b1;
                memWa       = q.word;
                memWd       = arrRsp.rdata;
                d.word      = q.word + 3'h1;
                if (q.word == 3'h5)
                begin
                    d.cmdDone = 1'b1;
                    d.st   = fcs_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            q      <= '0;
            q.st   <= fcs_pkg::ST_IDLE;
            q.cmdDone  <= 1'b1;
            q.secState <= 2'h3;
        end
        else
        begin
            q <= d;
        end
    end

    assign regRdata      = q.rdMem ? memRd : q.rdata;
    assign block0Invalid = q.st == fcs_pkg::ST_ONCE;

    // checks
    chk_index_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        regReq.rd && regReq.addr == fcs_pkg::OFS_INDEX |=> regRdata[15:3] == 13'h0000)
        else $error("index upper bits not zero");
    chk_prog_idx: assert property (@(posedge sys_clk) disable iff (sys_rst)
        q.st == fcs_pkg::ST_IDLE && d.st == fcs_pkg::ST_PROG && !d.once
        |-> q.idx == fcs_pkg::IDX_LAUNCH_PROG && gAddr[2:0] == 3'h0 && modeAllowed)
        else $error("program launched with bad index");
    chk_evs_idx: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(q.st == fcs_pkg::ST_EVS) |-> $past(q.idx) == fcs_pkg::IDX_LAUNCH_EVS
        && !$past(loadDataBusy))
        else $error("erase verify launched wrongly");
    chk_launch_err: assert property (@(posedge sys_clk) disable iff (sys_rst)
        launch && d.acc && !q.acc |=> q.cmdDone && q.st == fcs_pkg::ST_IDLE)
        else $error("command ran after launch error");
    chk_busy_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
        q.st != fcs_pkg::ST_IDLE |-> !q.cmdDone)
        else $error("complete flag set while busy");
    chk_block0_inv: assert property (@(posedge sys_clk) disable iff (sys_rst)
        q.st == fcs_pkg::ST_ONCE |-> block0Invalid)
        else $error("block 0 valid during read-once");
    chk_once_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(q.st == fcs_pkg::ST_ONCE) |-> ##[1:4] q.cmdDone)
        else $error("read-once did not finish");
    chk_sec_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        q.secState == 2'h2 |-> !isSecured(q.secState))
        else $error("security decode wrong");
    chk_no_pv_evs: assert property (@(posedge sys_clk) disable iff (sys_rst)
        q.st == fcs_pkg::ST_EVS |=> q.pv == $past(q.pv))
        else $error("erase verify touched protection flag");
    cov_prog: cover property (@(posedge sys_clk) $fell(q.st == fcs_pkg::ST_VERIFY));
    cov_once: cover property (@(posedge sys_clk) $fell(q.st == fcs_pkg::ST_ONCE));
    cov_acc:  cover property (@(posedge sys_clk) $rose(q.acc));
endmodule : fcs_sequencer
`default_nettype wire

// ---- test/flash_command_sequencer_tb.sv ----
// flash_command_sequencer_tb.sv: register-level self-checking bench of the sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequencer_tb;
    logic                  sys_clk;        // bus clock
    logic                  sys_rst;        // sync reset
    fcs_pkg::fcs_req_t     regReq;         // register request
    logic [15:0]           regRdata;       // register read data
    fcs_pkg::fcs_arr_req_t arrReq;         // array request
    fcs_pkg::fcs_arr_rsp_t arrRsp;         // array answer
    logic                  modeAllowed;    // mode permits commands
    logic                  loadDataBusy;   // load data active
    logic                  block0Invalid;  // block 0 reads invalid
    logic                  injErr;         // inject verify error
    logic                  injUnc;         // inject uncorrectable
    logic [15:0]           mem [4];        // phrase words of the array
    logic [15:0]           onceMem [32];   // info-area words, preset pattern
    logic [15:0]           rdq [$];        // info-area words fetched
    logic [22:0]           lastRd;         // last info-area fetched address
    logic [22:0]           lastWr;         // last programmed address
    int                    nWr;            // array word writes seen
    int                    infoWr;         // info-area word writes seen
    int                    failures;       // mismatches
    int                    n_checks;       // comparisons
    logic [15:0]           v;              // scratch read value
    int                    w0;             // scratch write count
    // launch-error cases: word0, word1, launch index, mode, load busy, status
    logic [15:0] ew0 [8] = '{16'h067c, 16'h067c, 16'h0610, 16'h067c,
                             16'h067f, 16'h037c, 16'h037c, 16'h0700};
    logic [15:0] ew1 [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0002,
                             16'h8000, 16'h0000, 16'h0000, 16'h0008};
    logic [2:0]  eix [8] = '{3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h1, 3'h2, 3'h1};
    logic [15:0] est [8] = '{16'h00a0, 16'h00a0, 16'h00a0, 16'h00a0,
                             16'h0090, 16'h00a0, 16'h00a0, 16'h00a0};
    logic [7:0]  eMode = 8'hfd;            // case 1 runs in a barred mode
    logic [7:0]  eLdb  = 8'h40;            // case 6 runs with load data busy

    fcs_sequencer #(.PROG_CNT(2)) dut_u (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .regReq        (regReq),
        .regRdata      (regRdata),
        .arrReq        (arrReq),
        .arrRsp        (arrRsp),
        .modeAllowed   (modeAllowed),
        .loadDataBusy  (loadDataBusy),
        .block0Invalid (block0Invalid)
    );

    // clock, 100 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // array answers in the same cycle; info area preset to an address pattern
    always_comb
    begin
        arrRsp.rdata = arrReq.info ? onceMem[arrReq.addr[5:1]] : mem[arrReq.addr[2:1]];
        arrRsp.err   = injErr & arrReq.rd;
        arrRsp.unc   = injUnc & arrReq.rd;
    end

    // array side bookkeeping of writes and distinct info fetches
    always @(posedge sys_clk)
    begin
        if (arrReq.wr === 1'b1)
        begin
            lastWr <= arrReq.addr;
            nWr <= nWr + 1;
            if (arrReq.info === 1'b1)
            begin
                onceMem[arrReq.addr[5:1]] <= arrReq.wdata;
                infoWr <= infoWr + 1;
            end
            else
                mem[arrReq.addr[2:1]] <= arrReq.wdata;
        end
        if (arrReq.rd === 1'b1 && arrReq.info === 1'b1 && arrReq.addr !== lastRd)
        begin
            rdq.push_back(arrRsp.rdata);
            lastRd <= arrReq.addr;
        end
    end

    // compare and count
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk

    // verdict and end of run
    task automatic test_done;
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // one-cycle write strobe, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        regReq <= '0;
        @(posedge sys_clk);
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        regReq <= '0;
        @(negedge sys_clk);
        d = regRdata;
        @(posedge sys_clk);
    endtask : rd

    // program data words
    function automatic logic [15:0] dat(input int k);
        return 16'h5a00 + 16'(k);
    endfunction : dat

    // load the six object words, set the index and launch
    task automatic cmd(input logic [15:0] a0, input logic [15:0] a1, input logic [2:0] ix);
        for (int k = 0; k < 6; k++)
        begin
            wr(fcs_pkg::OFS_INDEX, 16'(k));
            wr(fcs_pkg::OFS_OBJECT, (k == 0) ? a0 : (k == 1) ? a1 : dat(k));
        end
        wr(fcs_pkg::OFS_INDEX, {13'h0000, ix});
        wr(fcs_pkg::OFS_STATUS, 16'h0080);
    endtask : cmd

    // poll the complete flag under a bound, then check the status
    task automatic done(input logic [15:0] e);
        for (int i = 0; i < 100; i++)
        begin
            rd(fcs_pkg::OFS_STATUS, v);
            if (v[7] === 1'b1)
                break;
            if (i == 99)
            begin
                failures++;
                test_done();
            end
        end
        chk("status", e, v);
    endtask : done

    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        regReq = '0;
        modeAllowed = 1'b1;
        loadDataBusy = 1'b0;
        injErr = 1'b0;
        injUnc = 1'b0;
        lastRd = '1;
        lastWr = '0;
        nWr = 0;
        infoWr = 0;
        failures = 0;
        n_checks = 0;
        for (int k = 0; k < 4; k++)
            mem[k] = 16'hffff;
        for (int k = 0; k < 32; k++)
            onceMem[k] = 16'h3c00 ^ 16'(2 * k);
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // reset values, security decode, unmapped place
        rd(fcs_pkg::OFS_STATUS, v);
        chk("status", 16'h0080, v);
        rd(fcs_pkg::OFS_SECURITY, v);
        chk("security", 16'h0003, v);
        rd(fcs_pkg::OFS_CONTROL, v);
        chk("secured", 16'h0001, v & 16'h0001);
        for (int s = 0; s < 4; s++)
        begin
            wr(fcs_pkg::OFS_SECURITY, 16'(s));
            rd(fcs_pkg::OFS_CONTROL, v);
            chk("secured", (s == 2) ? 16'h0000 : 16'h0001, v);
        end
        rd(8'h40, v);
        chk("unmapped", 16'h0000, v);
        // index register keeps only its three low bits
        wr(fcs_pkg::OFS_INDEX, 16'hffff);
        rd(fcs_pkg::OFS_INDEX, v);
        chk("index", 16'h0007, v);
        // launch-time refusals, no array writes, flags cleared by ones
        for (int i = 0; i < 8; i++)
        begin
            modeAllowed <= eMode[i];
            loadDataBusy <= eLdb[i];
            w0 = nWr;
            cmd(ew0[i], ew1[i], eix[i]);
            repeat (3) @(posedge sys_clk);
            rd(fcs_pkg::OFS_STATUS, v);
            chk("launch error", est[i], v);
            chk("writes", 16'(w0), 16'(nWr));
            modeAllowed <= 1'b1;
            loadDataBusy <= 1'b0;
            wr(fcs_pkg::OFS_STATUS, 16'h0030);
            rd(fcs_pkg::OFS_STATUS, v);
            chk("cleared", 16'h0080, v);
        end
        // program a phrase: words written at the phrase, then verified
        w0 = nWr;
        cmd(16'h067c, 16'h0008, 3'h5);
        rd(fcs_pkg::OFS_STATUS, v);
        chk("busy", 16'h0000, v & 16'h0080);
        done(16'h0080);
        chk("writes", 16'(w0 + 4), 16'(nWr));
        chk("block", 16'h007c, 16'(lastWr[22:16]));
        chk("phrase", 16'h0008, {lastWr[15:3], 3'h0});
        for (int k = 0; k < 4; k++)
            chk("word", dat(k + 2), mem[k]);
        // verify errors of program and erase-verify
        for (int c = 0; c < 4; c++)
        begin
            injErr <= 1'b1;
            injUnc <= c[0];
            if (c < 2)
                cmd(16'h067c, 16'h0008, 3'h5);
            else
                cmd(16'h037f, 16'h8000, 3'h2);
            done(c[0] ? 16'h0083 : 16'h0082);
        end
        injErr <= 1'b0;
        injUnc <= 1'b0;
        // erase-verify on a protected place never flags protection
        cmd(16'h037f, 16'h8000, 3'h2);
        done(16'h0080);
        // read-once: block 0 invalid meanwhile, phrase lands in words 2..5
        rdq.delete();
        cmd(16'h0400, 16'h0003, 3'h0);
        chk("block0 invalid", 16'h0001, {15'h0000, block0Invalid});
        done(16'h0080);
        chk("block0 valid", 16'h0000, {15'h0000, block0Invalid});
        chk("fetches", 16'h0004, 16'(rdq.size()));
        for (int k = 0; k < 4; k++)
        begin
            wr(fcs_pkg::OFS_INDEX, 16'(k + 2));
            rd(fcs_pkg::OFS_OBJECT, v);
            chk("once word", 16'h3c00 ^ 16'(8 * 3 + 2 * k), v);
        end
        // program-once writes into the info area only
        w0 = infoWr;
        cmd(16'h0700, 16'h0002, 3'h1);
        done(16'h0080);
        chk("info writes", 16'(w0 + 4), 16'(infoWr));
        test_done();
    end
endmodule : flash_command_sequencer_tb
`default_nettype wire
